//--- liion_charge_pkg.sv
// Constants, types and register map of the single-cell charger control block.
// Assumes a 25 MHz reference clock and analog comparator results as digital inputs.
package liion_charge_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS        = 40;
    localparam int TICK_PERIOD_NS       = 1000000;  // 1 ms time base
    localparam int TICK_CYCLES          = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_HOURS_PER_UNIT = 3;        // Per 0.1 uF of timing capacitance
    localparam int MS_PER_UNIT          = TIMER_HOURS_PER_UNIT * 3600 * 1000;
    localparam int RECHARGE_FILTER_MS   = 4;        // Few ms of integration

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int TICK_W  = 15;
    localparam int TIMER_W = 28;
    localparam int FILT_W  = 3;
    localparam int CAP_W   = 4;
    localparam int ADDR_W  = 4;

    // ----------------------------------------
    // Register map (byte offsets) and fields
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_TCFG   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TCOUNT = 4'hC;
    localparam int CTRL_SHDN_BIT    = 0;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_C10_BIT     = 3;
    localparam int STAT_HOLD_BIT    = 4;
    localparam int STAT_ARMED_BIT   = 5;
    localparam int STAT_PIN_CHG_BIT = 8;
    localparam int STAT_PIN_FLT_BIT = 9;
    localparam int STAT_PIN_SUP_BIT = 10;
    localparam logic             CTRL_SHDN_RST = 1'b0;
    localparam logic [CAP_W-1:0] TCFG_CAP_RST  = 4'h1;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_SLEEP    = 3'b000,
        ST_SHUTDOWN = 3'b001,
        ST_TRICKLE  = 3'b010,
        ST_FAST     = 3'b011,
        ST_DONE     = 3'b100,
        ST_FAULT    = 3'b101
    } charge_state_e;

    typedef struct packed {
        logic supply_uv_ok;       // Supply above undervoltage lockout
        logic supply_margin_ok;   // Supply at least 30 mV above battery
        logic current_program_pin_shutdown;      // Program pin above shutdown threshold
        logic bat_above_trickle;  // Battery above trickle threshold
        logic tenth_current;      // Charge current at or below one tenth
        logic therm_hot;
        logic therm_cold;
        logic therm_disabled;     // Thermistor input grounded
        logic timer_pin_grounded;
        logic float_select;       // High selects the higher float voltage
        logic bat_above_arm;      // Battery above recharge arming level
        logic bat_below_recharge; // Battery below recharge threshold
    } analog_in_s;

endpackage

//--- liion_charge_state_control.sv
// Charge-cycle control of a single-cell linear charger with Avalon-MM registers.
// Assumes comparator results arrive synchronous to ref_clk; analog loops are outside.
`timescale 1ns/1ps

module liion_charge_state_control
    import liion_charge_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES,
    parameter int MS_PER_UNIT_P = MS_PER_UNIT
)(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire analog_in_s        cmp_in,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              charge_status_n_in,
    output logic                   charge_status_n_out,
    output logic                   charge_status_n_oe_n,
    output logic                   charge_weak_sink_en,
    input  wire logic              fault_n_in,
    output logic                   fault_n_out,
    output logic                   fault_n_oe_n,
    input  wire logic              supply_present_n_in,
    output logic                   supply_present_n_out,
    output logic                   supply_present_n_oe_n,
    output logic                   regulator_on,
    output logic                   trickle_current,
    output logic                   divider_connect,
    output logic                   float_4v2
);

    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        charge_state_e      state;
        logic [TICK_W-1:0]  tick_cnt;
        logic               tick;
        logic [TIMER_W-1:0] timer_ms;
        logic               c10;
        logic               armed;
        logic [FILT_W-1:0]  filt_cnt;
        analog_in_s         in;
        logic [2:0]         pins;
        logic               soft_shdn;
        logic [CAP_W-1:0]   cap_units;
        logic               ack;
        logic               waitreq;
        logic [31:0]        rdata;
        logic               chg_oe_n;
        logic               weak_en;
        logic               fault_oe_n;
        logic               sup_oe_n;
        logic               reg_on;
        logic               trickle_i;
        logic               div_en;
        logic               float_hi;
    } ctl_state_s;

    ctl_state_s         s_r;
    ctl_state_s         s_nxt;
    logic               supply_ok;
    logic               shdn;
    logic               hold;
    logic               timer_en;
    logic [TIMER_W-1:0] full_cnt;
    logic [TIMER_W-1:0] quarter_cnt;
    logic               expire_fast;
    logic               expire_trickle;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_charging(input charge_state_e st);
        is_charging = (st == ST_TRICKLE) || (st == ST_FAST);
    endfunction

    function automatic logic is_off(input charge_state_e st);
        is_off = (st == ST_SLEEP) || (st == ST_SHUTDOWN);
    endfunction

    // Qualifiers from sampled comparators
    assign supply_ok   = s_r.in.supply_uv_ok & s_r.in.supply_margin_ok;
    assign shdn        = s_r.in.current_program_pin_shutdown | s_r.soft_shdn;
    assign hold        = ~s_r.in.therm_disabled & (s_r.in.therm_hot | s_r.in.therm_cold);
    // A zero capacitance setting behaves like a grounded timer pin
    assign timer_en    = ~s_r.in.timer_pin_grounded & (s_r.cap_units != '0);
    assign full_cnt    = TIMER_W'(s_r.cap_units * MS_PER_UNIT_P);
    assign quarter_cnt = full_cnt >> 2;
    assign expire_fast    = timer_en & (s_r.timer_ms >= full_cnt);
    assign expire_trickle = timer_en & (s_r.timer_ms >= quarter_cnt) & ~s_r.in.bat_above_trickle;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        // One sampling stage for all comparators and pin readbacks
        s_nxt.in   = cmp_in;
        s_nxt.pins = {supply_present_n_in, fault_n_in, charge_status_n_in};

        // Millisecond time base
        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt == TICK_W'(TICK_CYCLES_P - 1))
        begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick     = 1'b1;
        end
        else
        begin
            s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
        end

        // Charge-cycle state machine; supply loss and shutdown override all
        if (!supply_ok)
        begin
            s_nxt.state    = ST_SLEEP;
            s_nxt.timer_ms = '0;
            s_nxt.c10      = 1'b0;
            s_nxt.armed    = 1'b0;
            s_nxt.filt_cnt = '0;
        end
        else if (shdn)
        begin
            s_nxt.state    = ST_SHUTDOWN;
            s_nxt.timer_ms = '0;
            s_nxt.c10      = 1'b0;
            s_nxt.armed    = 1'b0;
            s_nxt.filt_cnt = '0;
        end
        else
        begin
            case (s_r.state)
                ST_SLEEP, ST_SHUTDOWN:
                begin
                    // New cycle from a cleared timer
                    s_nxt.timer_ms = '0;
                    s_nxt.state    = s_r.in.bat_above_trickle ? ST_FAST : ST_TRICKLE;
                end
                ST_TRICKLE:
                begin
                    if (s_r.in.bat_above_trickle)
                        s_nxt.state = ST_FAST;
                    else if (expire_trickle)
                        s_nxt.state = ST_FAULT;
                    else if (s_r.tick && !hold && timer_en)
                        s_nxt.timer_ms = s_r.timer_ms + 1'b1;
                end
                ST_FAST:
                begin
                    if (expire_fast)
                        s_nxt.state = ST_DONE;
                    else if (s_r.tick && !hold && timer_en)
                        s_nxt.timer_ms = s_r.timer_ms + 1'b1;
                    // Latch holds until supply loss or shutdown
                    if (!hold && s_r.in.tenth_current)
                        s_nxt.c10 = 1'b1;
                end
                ST_DONE:
                begin
                    if (s_r.in.bat_above_arm)
                        s_nxt.armed = 1'b1;
                    // Any return above the threshold restarts the filter
                    if (!s_r.armed || !s_r.in.bat_below_recharge)
                        s_nxt.filt_cnt = '0;
                    else if (s_r.tick)
                        s_nxt.filt_cnt = s_r.filt_cnt + 1'b1;
                    if (s_r.filt_cnt == FILT_W'(RECHARGE_FILTER_MS))
                    begin
                        s_nxt.timer_ms = '0;
                        s_nxt.armed    = 1'b0;
                        s_nxt.filt_cnt = '0;
                        s_nxt.state    = s_r.in.bat_above_trickle ? ST_FAST : ST_TRICKLE;
                    end
                end
                ST_FAULT:
                begin
                    // Recharge comparator is ignored while latched
                    if (s_r.in.bat_above_trickle)
                    begin
                        s_nxt.state    = ST_FAST;
                        s_nxt.timer_ms = '0;
                    end
                end
                default:
                begin
                    s_nxt.state = ST_SLEEP;
                end
            endcase
        end

        // Charge, fault, regulator and divider controls follow the next state so they change with it
        s_nxt.chg_oe_n   = ~(is_charging(s_nxt.state) & ~s_nxt.c10);
        s_nxt.weak_en    = is_charging(s_nxt.state) & s_nxt.c10;
        s_nxt.fault_oe_n = ~((s_nxt.state == ST_FAULT) | (is_charging(s_nxt.state) & hold));
        s_nxt.sup_oe_n   = ~supply_ok;
        s_nxt.reg_on     = is_charging(s_nxt.state) & ~hold;
        s_nxt.trickle_i  = (s_nxt.state == ST_TRICKLE);
        s_nxt.div_en     = ~is_off(s_nxt.state);
        s_nxt.float_hi   = s_r.in.float_select;

        // Avalon slave: one wait cycle, then waitrequest low for one cycle
        s_nxt.ack     = (avs_read | avs_write) & ~s_r.ack;
        s_nxt.waitreq = ~s_nxt.ack;
        if (s_nxt.ack && avs_read)
        begin
            if (avs_address == OFS_CTRL)
                s_nxt.rdata = {31'h0, s_r.soft_shdn};
            else if (avs_address == OFS_TCFG)
                s_nxt.rdata = {28'h0, s_r.cap_units};
            else if (avs_address == OFS_STATUS)
                s_nxt.rdata = {21'h0, s_r.pins, 2'h0, s_r.armed, hold, s_r.c10, s_r.state};
            else if (avs_address == OFS_TCOUNT)
                s_nxt.rdata = {4'h0, s_r.timer_ms};
            else
                s_nxt.rdata = 32'h0;
        end
        // Writes land on the edge where waitrequest is seen low
        if (s_r.ack && avs_write && avs_byteenable[0])
        begin
            if (avs_address == OFS_CTRL)
                s_nxt.soft_shdn = avs_writedata[CTRL_SHDN_BIT];
            else if (avs_address == OFS_TCFG)
                s_nxt.cap_units = avs_writedata[CAP_W-1:0];
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s_r            <= '0;
            s_r.state      <= ST_SLEEP;
            s_r.soft_shdn  <= CTRL_SHDN_RST;
            s_r.cap_units  <= TCFG_CAP_RST;
            s_r.waitreq    <= 1'b1;
            s_r.chg_oe_n   <= 1'b1;
            s_r.fault_oe_n <= 1'b1;
            s_r.sup_oe_n   <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Open-drain pins only ever pull low; the enable decides
    assign charge_status_n_out   = 1'b0;
    assign fault_n_out           = 1'b0;
    assign supply_present_n_out  = 1'b0;
    assign charge_status_n_oe_n  = s_r.chg_oe_n;
    assign charge_weak_sink_en   = s_r.weak_en;
    assign fault_n_oe_n          = s_r.fault_oe_n;
    assign supply_present_n_oe_n = s_r.sup_oe_n;
    assign regulator_on          = s_r.reg_on;
    assign trickle_current       = s_r.trickle_i;
    assign divider_connect       = s_r.div_en;
    assign float_4v2             = s_r.float_hi;
    assign avs_readdata          = s_r.rdata;
    assign avs_waitrequest       = s_r.waitreq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_strong_pulldown: assert property (
        (supply_ok && !shdn && s_r.state == ST_FAST && !expire_fast && !s_r.c10 && (hold || !s_r.in.tenth_current))
        |=> !charge_status_n_oe_n && !charge_weak_sink_en)
        else $error("charge status not driven low while charging");

    a_c10_switch: assert property (
        (supply_ok && !shdn && s_r.state == ST_FAST && !expire_fast && !hold && s_r.in.tenth_current)
        |=> charge_status_n_oe_n && charge_weak_sink_en && s_r.c10)
        else $error("tenth current did not move status pin to weak sink");

    a_c10_sticky: assert property (
        (s_r.c10 && supply_ok && !shdn) |=> s_r.c10)
        else $error("tenth current latch dropped without clear");

    a_timeout_float: assert property (
        (supply_ok && !shdn && s_r.state == ST_FAST && expire_fast)
        |=> s_r.state == ST_DONE && charge_status_n_oe_n && !charge_weak_sink_en)
        else $error("timer expiry did not float status pin");

    a_sleep_entry: assert property (
        !supply_ok |=> s_r.state == ST_SLEEP && !divider_connect && supply_present_n_oe_n && !regulator_on)
        else $error("sleep not entered on supply loss");

    a_trickle_fault: assert property (
        (supply_ok && !shdn && s_r.state == ST_TRICKLE && expire_trickle)
        |=> s_r.state == ST_FAULT && !fault_n_oe_n && charge_status_n_oe_n)
        else $error("trickle timeout did not latch fault");

    a_fault_latched: assert property (
        (s_r.state == ST_FAULT && supply_ok && !shdn && !s_r.in.bat_above_trickle)
        |=> s_r.state == ST_FAULT ##1 s_r.state == ST_FAULT || !supply_ok || shdn || s_r.in.bat_above_trickle)
        else $error("trickle fault cleared without cause");

    a_hold_freeze: assert property (
        (supply_ok && !shdn && s_r.state == ST_FAST && !expire_fast && hold)
        |=> $stable(s_r.timer_ms) && !regulator_on)
        else $error("timer moved or regulator on during hold");

    a_hold_fault: assert property (
        (supply_ok && !shdn && s_r.state == ST_FAST && !expire_fast && hold)
        |=> !fault_n_oe_n && (charge_status_n_oe_n == $past(charge_status_n_oe_n)))
        else $error("hold did not pull fault or changed status pin");

    a_shdn_reset: assert property (
        (supply_ok && shdn) |=> s_r.timer_ms == '0 && !regulator_on && !divider_connect)
        else $error("shutdown left timer or regulator running");

    a_timer_off: assert property (
        (supply_ok && !shdn && s_r.state == ST_TRICKLE && !timer_en && !s_r.in.bat_above_trickle)
        |=> s_r.state == ST_TRICKLE)
        else $error("timeout with timer disabled");

    a_recharge_go: assert property (
        (supply_ok && !shdn && s_r.state == ST_DONE && s_r.filt_cnt == FILT_W'(RECHARGE_FILTER_MS))
        |=> is_charging(s_r.state) && s_r.timer_ms == '0)
        else $error("filtered recharge did not start a cycle");

    a_bus_answer: assert property (
        ((avs_read || avs_write) && avs_waitrequest && !s_r.ack) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

endmodule

//--- battery_pack_model.sv
// Battery pack, thermistor, supply and status-pin host around the charger.
// Assumes the bench sets the analog levels below by hierarchical assignment.
`timescale 1ns/1ps
module battery_pack_model
    import liion_charge_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic chg_oe_n,
    input  wire logic flt_oe_n,
    input  wire logic sup_oe_n,
    output analog_in_s cmp_in,
    output logic       chg_pin,
    output logic       flt_pin,
    output logic       sup_pin
);
    int   vcc_mv  = 0;
    int   bat_mv  = 0;
    int   current_program_pin_mv = 0;      // Resistor to ground; no pull-up on the pin
    int   ntc_mv  = 3500;
    logic sel     = 1'b0;
    logic low_i   = 1'b0;
    logic tmr_gnd = 1'b0;   // Grounding the timer pin disables timeouts

    // Host pull-ups read the open-drain pins
    assign chg_pin = chg_oe_n;
    assign flt_pin = flt_oe_n;
    assign sup_pin = sup_oe_n;

    // Comparators switch just after an edge, as a synchroniser would see them
    always @(posedge ref_clk)
    begin
        cmp_in.supply_uv_ok       <= vcc_mv > 4200;
        cmp_in.supply_margin_ok   <= vcc_mv >= bat_mv + 30;
        cmp_in.current_program_pin_shutdown      <= current_program_pin_mv > 2150;
        cmp_in.bat_above_trickle  <= bat_mv > 2480;
        cmp_in.tenth_current      <= low_i;
        cmp_in.therm_hot          <= ntc_mv * 2 < vcc_mv;
        cmp_in.therm_cold         <= ntc_mv * 8 > vcc_mv * 7;
        cmp_in.therm_disabled     <= ntc_mv < 100;
        cmp_in.timer_pin_grounded <= tmr_gnd;
        cmp_in.float_select       <= sel;
        cmp_in.bat_above_arm      <= bat_mv > (sel ? 4050 : 3950);
        cmp_in.bat_below_recharge <= bat_mv < (sel ? 4000 : 3900);
    end
endmodule

//--- liion_charge_state_control_test.sv
// Self-checking bench for the charger control block.
// Assumes the pack model on the far side and a shortened time base.
`timescale 1ns/1ps
module liion_charge_state_control_test
    import liion_charge_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic avs_waitrequest, chg_pin, flt_pin, sup_pin, chg_oe_n, flt_oe_n, sup_oe_n;
    logic weak_en, reg_on, trk, div_on, f42, chg_out, flt_out, sup_out;
    analog_in_s cmp_in;
    int fails = 0, checks_done = 0;

    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #20 ref_clk = ~ref_clk;

    // Short tick and unit: quarter time is 5 ms, full time 20 ms
    liion_charge_state_control #(.TICK_CYCLES_P(4), .MS_PER_UNIT_P(20)) dut_u (.ref_clk(ref_clk),
        .srst(srst), .cmp_in(cmp_in), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .charge_status_n_in(chg_pin), .charge_status_n_out(chg_out), .charge_status_n_oe_n(chg_oe_n),
        .charge_weak_sink_en(weak_en), .fault_n_in(flt_pin), .fault_n_out(flt_out), .fault_n_oe_n(flt_oe_n),
        .supply_present_n_in(sup_pin), .supply_present_n_out(sup_out), .supply_present_n_oe_n(sup_oe_n),
        .regulator_on(reg_on), .trickle_current(trk), .divider_connect(div_on), .float_4v2(f42));

    battery_pack_model pack_u (.ref_clk(ref_clk), .chg_oe_n(chg_oe_n), .flt_oe_n(flt_oe_n),
        .sup_oe_n(sup_oe_n), .cmp_in(cmp_in), .chg_pin(chg_pin), .flt_pin(flt_pin), .sup_pin(sup_pin));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Holds the request until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task stop_test;
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        chk({chg_oe_n, flt_oe_n, sup_oe_n, reg_on}, 4'hE);
        chk({chg_out, flt_out, sup_out}, 3'h0);
        bus(1'b0, OFS_TCFG, '0);
        chk(q, TCFG_CAP_RST);
        bus(1'b0, 4'h1, '0);  // Unmapped reads as zero
        chk(q, 32'h0);
    endtask

    task t_trickle_fault;
        pack_u.vcc_mv <= 5000;
        pack_u.bat_mv <= 2000;
        wt(10);
        chk({chg_oe_n, trk, sup_oe_n, div_on, flt_oe_n}, 5'h0B);
        chk(f42, 1'b0);
        wt(25);
        chk({flt_oe_n, chg_oe_n, reg_on}, 3'h2);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[2:0], ST_FAULT);
        chk(q[10:8], 3'h1);
        pack_u.bat_mv <= 3000;  // Lifting the battery node clears the fault
        wt(5);
        chk({flt_oe_n, chg_oe_n, trk, reg_on}, 4'h9);
    endtask

    task t_hold;
        pack_u.ntc_mv <= 2000;
        wt(5);
        chk({flt_oe_n, reg_on, chg_oe_n}, 3'h0);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[4], 1'b1);
        pack_u.ntc_mv <= 50;   // Grounded input overrides the hot reading
        wt(5);
        chk({flt_oe_n, reg_on}, 2'h3);
        pack_u.ntc_mv <= 3500;
    endtask

    task t_tenth_and_timeout;
        pack_u.low_i <= 1'b1;
        wt(5);
        chk({weak_en, chg_oe_n}, 2'h3);
        pack_u.low_i <= 1'b0;
        wt(5);
        chk({weak_en, chg_oe_n}, 2'h3);
        wt(100);
        chk({weak_en, chg_oe_n, reg_on}, 3'h2);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[2:0], ST_DONE);
    endtask

    task t_recharge;
        pack_u.bat_mv <= 4000;
        wt(5);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[5], 1'b1);
        pack_u.bat_mv <= 3800;
        wt(40);
        bus(1'b0, OFS_STATUS, '0);
        // Tenth-current latch survives a recharge restart, so the weak sink comes back on
        chk({q[2:0], chg_oe_n, weak_en}, {ST_FAST, 1'b1, 1'b1});
    endtask

    task t_shutdown;
        pack_u.current_program_pin_mv <= 2500;
        wt(5);
        chk({reg_on, div_on, chg_oe_n}, 3'h1);
        bus(1'b0, OFS_STATUS, '0);
        chk({q[3], q[2:0]}, {1'b0, ST_SHUTDOWN});
        bus(1'b0, OFS_TCOUNT, '0);
        chk(q, 32'h0);
        pack_u.current_program_pin_mv <= 0;
        wt(5);
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[2:0], ST_SHUTDOWN);
        bus(1'b1, OFS_CTRL, 32'h0);
        pack_u.sel <= 1'b1;
        wt(5);
        chk(f42, 1'b1);
    endtask

    task t_no_timer;
        pack_u.current_program_pin_mv <= 2500;
        pack_u.bat_mv <= 2000;
        pack_u.tmr_gnd <= 1'b1;
        wt(3);
        pack_u.current_program_pin_mv <= 0;
        wt(50);
        chk({flt_oe_n, trk, chg_oe_n}, 3'h6);
    endtask

    task t_sleep;
        pack_u.bat_mv <= 4985;  // Supply now within 30 mV of the battery
        wt(5);
        chk({sup_oe_n, reg_on, div_on, chg_oe_n}, 4'h9);
        bus(1'b0, OFS_STATUS, '0);
        chk(q[2:0], ST_SLEEP);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        wt(8);
        srst <= 1'b0;
        t_reset();
        t_trickle_fault();
        t_hold();
        t_tenth_and_timeout();
        t_recharge();
        t_shutdown();
        t_no_timer();
        t_sleep();
        stop_test();
    end

    // Whole run is about 330 cycles; fifteen times that means a hang
    initial
    begin
        wt(5000);
        fails++;
        stop_test();
    end
endmodule
